// *** shared/tlpiu_defs.svh ***
// Purpose: Constants for the two level priority interrupt unit
// Assumes: Included by bare name wherever offsets, fields or counts are needed
// Notes:   Register indices are word indices; byte address is four times the index
`ifndef TLPIU_DEFS_SVH
`define TLPIU_DEFS_SVH

// Register indices
`define TLPIU_IDX_CONTROL   2'h0
`define TLPIU_IDX_RESETCTL  2'h1
`define TLPIU_IDX_PERIPH    2'h2
`define TLPIU_IDX_STATUS    2'h3

// Control register field positions
`define TLPIU_BIT_GLB_HIGH  7
`define TLPIU_BIT_GLB_LOW   6
`define TLPIU_BIT_TMR_EN    5
`define TLPIU_BIT_EXT_EN    4
`define TLPIU_BIT_PORT_EN   3
`define TLPIU_BIT_TMR_FLAG  2
`define TLPIU_BIT_EXT_FLAG  1
`define TLPIU_BIT_PORT_FLAG 0

// Reset control register field
`define TLPIU_BIT_PRIO_MODE 7

// Vector addresses
`define TLPIU_VEC_HIGH      21'h000008
`define TLPIU_VEC_LOW       21'h000018

// Vectoring latency for external events, in instruction cycles
`define TLPIU_EXT_LAT_MIN   3
`define TLPIU_EXT_LAT_MAX   4

// Reset values
`define TLPIU_RST_CONTROL   8'h00
`define TLPIU_RST_BYTE      8'h00

`endif

// *** shared/tlpiu_pkg.sv ***
// Purpose: Types for the two level priority interrupt unit
// Assumes: Constants live in tlpiu_defs.svh
// Notes:   Holds the sequencer state enumeration only
package tlpiu_pkg;

	// Vectoring sequencer states
	typedef enum logic [1:0] {
		TLPIU_IDLE,
		TLPIU_WAIT,
		TLPIU_VECTOR
	} tlpiu_seq_t;

endpackage

// *** hdl/tlpiu_sync.sv ***
// Purpose: Three stage pin synchroniser with agreement filter
// Assumes: Input is asynchronous to clk_i
// Notes:   Output follows only when stages two and three agree
`timescale 1ns/1ps
module tlpiu_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk_i,
	input  wire logic             rst_i,
	input  wire logic [WIDTH-1:0] async_i,
	output logic      [WIDTH-1:0] sync_o
);
	import tlpiu_pkg::*;

	// Synchroniser state
	typedef struct packed {
		logic [WIDTH-1:0] s1;   // First stage, read only by s2
		logic [WIDTH-1:0] s2;   // Second stage
		logic [WIDTH-1:0] s3;   // Third stage
		logic [WIDTH-1:0] outv; // Filtered level
	} tlpiu_sync_st_t;

	tlpiu_sync_st_t st_q;
	tlpiu_sync_st_t st_d;

	// Next state: shift and accept agreed bits
	always_comb begin
		st_d = st_q;
		st_d.s1 = async_i;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.outv[i] = st_q.s3[i];
			end
		end
	end

	// Register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sync_o = st_q.outv;
endmodule // tlpiu_sync

// *** hdl/tlpiu_wb.sv ***
// Purpose: Classic Wishbone slave front end for the interrupt unit
// Assumes: 32-bit bus, word aligned registers, four register words
// Notes:   Ack one cycle after request, dropped the next cycle
`timescale 1ns/1ps
`include "tlpiu_defs.svh"
module tlpiu_wb (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [3:0]  adr_i,
	input  wire logic [31:0] dat_i,
	input  wire logic [7:0]  rdata_i,
	output logic             ack_o,
	output logic [31:0]      dat_o,
	output logic             wr_o,
	output logic             rd_o,
	output logic [1:0]       idx_o,
	output logic [7:0]       wdata_o
);
	import tlpiu_pkg::*;

	// Bus slave state
	typedef struct packed {
		logic        ack;  // Acknowledge
		logic [31:0] dat;  // Read data
	} tlpiu_wb_st_t;

	tlpiu_wb_st_t st_q;
	tlpiu_wb_st_t st_d;
	logic         req;     // Fresh request

	assign req     = cyc_i && stb_i && !st_q.ack;
	assign idx_o   = adr_i[3:2];
	assign wdata_o = dat_i[7:0];
	// Write strobe only when the low lane is selected
	assign wr_o    = req && we_i && sel_i[0];
	assign rd_o    = req && !we_i;

	// Answer every request, mapped or not; narrow data in low byte
	always_comb begin
		st_d = st_q;
		st_d.ack = req;
		if (req && !we_i) begin
			st_d.dat = {24'h000000, rdata_i};
		end
	end

	// Register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign ack_o = st_q.ack;
	assign dat_o = st_q.dat;
endmodule // tlpiu_wb

// *** hdl/tlpiu_top.sv ***
// Purpose: Two level priority interrupt unit for an 8-bit core
// Assumes: clk_i is the 40 MHz instruction clock, one edge per instruction cycle
// Notes:   Core takes vectors on irq_take_o and signals return on retirq_i
//
// Chosen here: the address map and the Wishbone slave port.
`timescale 1ns/1ps
`include "tlpiu_defs.svh"

module tlpiu_top #(
	parameter int NPERIPH = 8
) (
	input  wire logic               clk_i,
	input  wire logic               rst_i,
	input  wire logic               wb_cyc_i,
	input  wire logic               wb_stb_i,
	input  wire logic               wb_we_i,
	input  wire logic [3:0]         wb_sel_i,
	input  wire logic [3:0]         wb_adr_i,
	input  wire logic [31:0]        wb_dat_i,
	output logic                    wb_ack_o,
	output logic [31:0]             wb_dat_o,
	input  wire logic               timer_zero_ovf_i,
	input  wire logic               ext_irq_pin_zero_i,
	input  wire logic               ext_edge_rising_i,
	input  wire logic [3:0]         upper_port_pins_i,
	input  wire logic               port_read_i,
	input  wire logic [NPERIPH-1:0] periph_req_i,
	input  wire logic               timer_zero_prio_i,
	input  wire logic               ext_pin_zero_prio_i,
	input  wire logic               port_change_prio_i,
	input  wire logic               retirq_i,
	input  wire logic [20:0]        ret_addr_i,
	input  wire logic               core_ack_i,
	output logic                    irq_take_o,
	output logic [20:0]             irq_vector_o,
	output logic                    stack_push_o,
	output logic [20:0]             stack_data_o,
	output logic                    in_high_o,
	output logic                    in_low_o
);
	import tlpiu_pkg::*;

	// How the unit works, in brief:
	// Three core sources keep their enable and flag bits in the control
	// register; up to eight peripheral requests arrive as levels and are
	// gated by the peripheral enable and priority words.
	// Each cycle the eligibility logic decides whether a high or a low
	// request may be taken, given the mode, the global enables and the
	// service levels already running.
	// The sequencer then waits a fixed time, raises the vector strobe,
	// clears the permitting global enable and marks the level as active.
	// The strobe stands until the core says it has taken the vector.
	// A return pulse from the core closes the innermost active level and
	// sets its global enable again.
	// Hazard: flags that software forgets to clear re-enter the routine
	// at once when the enable is restored; nothing here prevents that.

	// Whole unit state
	typedef struct packed {
		logic [7:0]  ctrl;      // Control register
		logic        prio_mode; // Reset control mode bit
		logic [7:0]  penable;   // Peripheral enables
		logic [7:0]  pprio;     // Peripheral priorities
		logic [3:0]  latch;     // Port value latched at last read
		logic        ext_prev;  // Previous pin level
		tlpiu_seq_t  seq;       // Vectoring sequencer
		logic [1:0]  lat;       // External latency counter
		logic        sel_high;  // Pending vector is high
		logic        act_high;  // High service running
		logic        act_low;   // Low service running
		logic [20:0] vec;       // Vector output
		logic [20:0] ret;       // Return address output
		logic        take;      // Vector strobe
	} tlpiu_st_t;

	tlpiu_st_t  st_q;
	tlpiu_st_t  st_d;
	logic       bus_wr;         // Register write strobe
	logic [1:0] bus_idx;        // Register index
	logic [7:0] bus_wdata;      // Write byte
	logic [7:0] rdata;          // Read mux
	logic       ext_s;          // Synchronised pin
	logic [3:0] port_s;         // Synchronised port pins
	logic       tmr_ev;         // Timer event this cycle
	logic       ext_ev;         // Pin edge this cycle
	logic       port_ev;        // Mismatch this cycle
	logic [2:0] core_req;       // Core source requests
	logic [2:0] core_prio;      // Core source priorities
	logic [7:0] preq;           // Peripheral requests
	logic       want_high;      // Eligible high request
	logic       want_low;       // Eligible low request

	// Level of an accepted request or running service
	// Compatibility mode has one enable and one vector, so all is high
	function automatic logic lvl_high(input logic mode, input logic high);
		lvl_high = !mode || high;
	endfunction

	// Any source asking at one level
	// The selects pick the sources that belong to that level
	function automatic logic lvl_any(
		input logic [2:0] creq,
		input logic [2:0] csel,
		input logic [7:0] pr,
		input logic [7:0] psel
	);
		lvl_any = |(creq & csel) || |(pr & psel);
	endfunction

	// Register bus front end
	tlpiu_wb u_wb (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.cyc_i   (wb_cyc_i),
		.stb_i   (wb_stb_i),
		.we_i    (wb_we_i),
		.sel_i   (wb_sel_i),
		.adr_i   (wb_adr_i),
		.dat_i   (wb_dat_i),
		.rdata_i (rdata),
		.ack_o   (wb_ack_o),
		.dat_o   (wb_dat_o),
		.wr_o    (bus_wr),
		.rd_o    (),
		.idx_o   (bus_idx),
		.wdata_o (bus_wdata)
	);

	// Pin synchronisers
	tlpiu_sync #(.WIDTH(5)) u_sync (
		.clk_i   (clk_i),
		.rst_i   (rst_i),
		.async_i ({ext_irq_pin_zero_i, upper_port_pins_i}),
		.sync_o  ({ext_s, port_s})
	);

	// Event detection; events set flags with no enable involved
	assign tmr_ev  = timer_zero_ovf_i;
	assign ext_ev  = (ext_s != st_q.ext_prev) && (ext_s == ext_edge_rising_i);
	assign port_ev = (port_s != st_q.latch);

	// Source requests: flag and enable per source
	assign core_req  = {st_q.ctrl[`TLPIU_BIT_TMR_FLAG] & st_q.ctrl[`TLPIU_BIT_TMR_EN],
		st_q.ctrl[`TLPIU_BIT_EXT_FLAG] & st_q.ctrl[`TLPIU_BIT_EXT_EN],
		st_q.ctrl[`TLPIU_BIT_PORT_FLAG] & st_q.ctrl[`TLPIU_BIT_PORT_EN]};
	assign core_prio = {timer_zero_prio_i, ext_pin_zero_prio_i, port_change_prio_i};
	assign preq      = periph_req_i[7:0] & st_q.penable;

	// Eligibility of high and low requests in either mode
	// In priority mode a running high service blocks everything, and a
	// running low service blocks only further low requests, so a high
	// request may nest inside a low service but never the other way.
	// Clearing bit 7 blocks both levels: low requests need both bits.
	// In compatibility mode the priority inputs are not looked at;
	// core sources need bit 7, peripherals need bit 7 and bit 6.
	always_comb begin
		want_high = 1'b0;
		want_low  = 1'b0;
		if (st_q.prio_mode) begin
			// Bit 7 gates high; low needs bit 7 and bit 6
			want_high = st_q.ctrl[`TLPIU_BIT_GLB_HIGH] &&
				lvl_any(core_req, core_prio, preq, st_q.pprio);
			want_low  = st_q.ctrl[`TLPIU_BIT_GLB_HIGH] && st_q.ctrl[`TLPIU_BIT_GLB_LOW] &&
				lvl_any(core_req, ~core_prio, preq, ~st_q.pprio);
			// Low service cannot preempt itself; high cannot be preempted
			if (st_q.act_high) begin
				want_high = 1'b0;
				want_low  = 1'b0;
			end else if (st_q.act_low) begin
				want_low = 1'b0;
			end
		end else begin
			// Priority bits unused; peripherals need bit 6 as well
			want_high = st_q.ctrl[`TLPIU_BIT_GLB_HIGH] && (|core_req ||
				(st_q.ctrl[`TLPIU_BIT_GLB_LOW] && |preq));
		end
	end

	// Register read mux; all four word indices are mapped
	always_comb begin
		unique case (bus_idx)
			`TLPIU_IDX_CONTROL:  rdata = st_q.ctrl;
			`TLPIU_IDX_RESETCTL: rdata = {st_q.prio_mode, 7'h00};
			`TLPIU_IDX_PERIPH:   rdata = st_q.penable;
			`TLPIU_IDX_STATUS:   rdata = st_q.pprio;
		endcase
	end

	// Next state of the whole unit
	always_comb begin
		st_d = st_q;
		st_d.take = 1'b0;
		st_d.ext_prev = ext_s;
		// Software writes
		if (bus_wr) begin
			unique case (bus_idx)
				`TLPIU_IDX_CONTROL: begin
					// Flags only clear by zero writes; enables store
					st_d.ctrl[`TLPIU_BIT_GLB_HIGH:`TLPIU_BIT_PORT_EN] =
						bus_wdata[`TLPIU_BIT_GLB_HIGH:`TLPIU_BIT_PORT_EN];
					st_d.ctrl[`TLPIU_BIT_TMR_FLAG:`TLPIU_BIT_PORT_FLAG] =
						st_q.ctrl[`TLPIU_BIT_TMR_FLAG:`TLPIU_BIT_PORT_FLAG] &
						bus_wdata[`TLPIU_BIT_TMR_FLAG:`TLPIU_BIT_PORT_FLAG];
				end
				`TLPIU_IDX_RESETCTL: st_d.prio_mode = bus_wdata[`TLPIU_BIT_PRIO_MODE];
				`TLPIU_IDX_PERIPH:   st_d.penable = bus_wdata;
				`TLPIU_IDX_STATUS:   st_d.pprio = bus_wdata;
			endcase
		end
		// Reading the port ends the mismatch
		if (port_read_i) begin
			st_d.latch = port_s;
		end
		// Hardware sets win over a same cycle clear
		if (tmr_ev) begin
			st_d.ctrl[`TLPIU_BIT_TMR_FLAG] = 1'b1;
		end
		if (ext_ev) begin
			st_d.ctrl[`TLPIU_BIT_EXT_FLAG] = 1'b1;
		end
		if (port_ev) begin
			st_d.ctrl[`TLPIU_BIT_PORT_FLAG] = 1'b1;
		end
		// Return restores the enable of the service being left
		// With both levels active the high one is innermost and ends first
		if (retirq_i) begin
			if (lvl_high(st_q.prio_mode, st_q.act_high)) begin
				st_d.ctrl[`TLPIU_BIT_GLB_HIGH] = 1'b1;
				st_d.act_high = 1'b0;
			end else begin
				st_d.ctrl[`TLPIU_BIT_GLB_LOW] = 1'b1;
				st_d.act_low = 1'b0;
			end
		end

		// Vectoring sequencer
		// IDLE: picks the level at the edge where a request is eligible;
		// high wins when both ask, and low simply stays pending.
		// WAIT: counts a fixed number of cycles so that the answer time
		// does not depend on the instruction being interrupted.
		// VECTOR: strobe stands until the core acknowledges it.
		// The enable is cleared at the same edge as the strobe rises, so a
		// second request cannot slip in while the core is still answering.
		// The return address is captured at that edge as well.
		unique case (st_q.seq)
			TLPIU_IDLE: begin
				if (want_high || want_low) begin
					st_d.sel_high = want_high;
					st_d.lat = 2'(`TLPIU_EXT_LAT_MIN - 2);
					st_d.seq = TLPIU_WAIT;
				end
			end
			TLPIU_WAIT: begin
				// Fixed delay, independent of the interrupted instruction
				if (st_q.lat == 2'h0) begin
					st_d.seq = TLPIU_VECTOR;
					st_d.take = 1'b1;
					st_d.vec = lvl_high(st_q.prio_mode, st_q.sel_high) ?
						`TLPIU_VEC_HIGH : `TLPIU_VEC_LOW;
					st_d.ret = ret_addr_i;
					if (lvl_high(st_q.prio_mode, st_q.sel_high)) begin
						st_d.ctrl[`TLPIU_BIT_GLB_HIGH] = 1'b0;
						st_d.act_high = 1'b1;
					end else begin
						st_d.ctrl[`TLPIU_BIT_GLB_LOW] = 1'b0;
						st_d.act_low = 1'b1;
					end
				end else begin
					st_d.lat = st_q.lat - 2'h1;
				end
			end
			TLPIU_VECTOR: begin
				// Hold vector until the core has taken it
				if (core_ack_i) begin
					st_d.seq = TLPIU_IDLE;
				end else begin
					st_d.take = 1'b1;
				end
			end
		endcase
	end

	// The port flag has no defined power-on value; zero is chosen so the
	// unit never vectors straight out of reset.
	// Software must still clear it before enabling the port source,
	// since any difference on the pins sets it again.

	// State register; port flag resets to zero as its unknown value
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_q <= '0;
			st_q.ctrl <= `TLPIU_RST_CONTROL;
			st_q.seq <= TLPIU_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// The push strobe is combinational so that it drops in the cycle in
	// which the core answers; the core must push only once per vector.
	// All other core side outputs come straight from flip-flops.

	// Core side outputs
	assign irq_take_o   = st_q.take;
	assign stack_push_o = st_q.take && st_q.seq == TLPIU_VECTOR && !core_ack_i;
	assign irq_vector_o = st_q.vec;
	assign stack_data_o = st_q.ret;
	assign in_high_o    = st_q.act_high;
	assign in_low_o     = st_q.act_low;
endmodule // tlpiu_top

// *** bench/tlpiu_asserts.sv ***
// Purpose: Concurrent checks on the interrupt unit ports
// Assumes: Bound to tlpiu_top from the bench top file
// Notes:   One clock domain, so default clocking is used
`timescale 1ns/1ps
module tlpiu_asserts (
	input wire logic        clk_i,
	input wire logic        rst_i,
	input wire logic        wb_cyc_i,
	input wire logic        wb_stb_i,
	input wire logic        wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire logic        core_ack_i,
	input wire logic        retirq_i,
	input wire logic        irq_take_o,
	input wire logic [20:0] irq_vector_o,
	input wire logic        stack_push_o,
	input wire logic [20:0] stack_data_o,
	input wire logic        in_high_o,
	input wire logic        in_low_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// Bus answers after one cycle, for one cycle
	chk_bus_ack: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack wrong");
	chk_read_width: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h000000)
		else $error("read data upper bits set");
	chk_vector_addr: assert property (irq_take_o |->
		irq_vector_o == 21'h000008 || irq_vector_o == 21'h000018) else $error("bad vector");
	chk_take_hold: assert property (irq_take_o && !core_ack_i |=>
		irq_take_o && $stable(irq_vector_o) && $stable(stack_data_o)) else $error("take dropped");
	chk_take_end: assert property (irq_take_o && core_ack_i |=> !irq_take_o)
		else $error("take held after core ack");
	chk_stack_push: assert property (irq_take_o |-> stack_push_o == !core_ack_i)
		else $error("push mismatch");
	chk_low_vector: assert property ($rose(in_low_o) |->
		irq_take_o && irq_vector_o == 21'h000018) else $error("low entry without low vector");
	chk_high_vector: assert property ($rose(in_high_o) |->
		irq_take_o && irq_vector_o == 21'h000008) else $error("high entry without high vector");
	chk_ret_high: assert property (retirq_i && in_high_o |=>
		!in_high_o && in_low_o == $past(in_low_o)) else $error("return from high wrong");
	chk_ret_low: assert property (retirq_i && !in_high_o |=> !in_low_o)
		else $error("return from low wrong");
endmodule // tlpiu_asserts

// *** bench/tlpiu_core_model.sv ***
// Purpose: Behavioural core that takes vectors and executes returns
// Assumes: Shares the instruction clock with the interrupt unit
// Notes:   Answer lag is set by the bench, prompt or slow
`timescale 1ns/1ps
module tlpiu_core_model (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        take_i,
	input  wire logic [20:0] vec_i,
	input  wire logic        ret_cmd_i,
	input  wire logic [1:0]  lag_i,
	output logic             ack_o,
	output logic             retirq_o,
	output logic [20:0]      pc_o
);
	logic [1:0] wait_q; // Cycles spent before answering
	// Counter runs; acknowledges a vector after the lag
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pc_o     <= 21'h000100;
			ack_o    <= 1'b0;
			retirq_o <= 1'b0;
			wait_q   <= 2'h0;
		end else begin
			retirq_o <= ret_cmd_i;
			if (take_i && !ack_o) begin
				wait_q <= wait_q + 2'h1;
				ack_o  <= (wait_q == lag_i);
			end else begin
				wait_q <= 2'h0;
				ack_o  <= 1'b0;
			end
			pc_o <= ack_o ? vec_i : pc_o + 21'h000001;
		end
	end
endmodule // tlpiu_core_model

// *** bench/tb.sv ***
// Purpose: Self-checking bench for the interrupt unit
// Assumes: Core model answers vectors; bench plays software and pins
// Notes:   Each scenario is a task that judges its own results
`timescale 1ns/1ps
module tb;
	logic        clk_i = 1'b0, rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]  sel = 4'h0, adr = 4'h0, upins = 4'h0;
	logic [31:0] dat = 32'h0, rdat;
	logic        tov = 1'b0, extp = 1'b0, prd = 1'b0, tpr = 1'b0, epr = 1'b0, retc = 1'b0;
	logic [7:0]  preq = 8'h00, q;
	logic [1:0]  lag = 2'h0;
	logic        ack, take, push, inh, inl, cack, rirq;
	logic [20:0] vec, sdata, pc;
	int          num_errors = 0, tests_run = 0, cyc_n = 0;
	always #12.5 clk_i = ~clk_i; // 25 ns period
	tlpiu_top uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_sel_i(sel), .wb_adr_i(adr), .wb_dat_i(dat), .wb_ack_o(ack), .wb_dat_o(rdat),
		.timer_zero_ovf_i(tov), .ext_irq_pin_zero_i(extp), .ext_edge_rising_i(1'b1),
		.upper_port_pins_i(upins), .port_read_i(prd), .periph_req_i(preq),
		.timer_zero_prio_i(tpr), .ext_pin_zero_prio_i(epr), .port_change_prio_i(1'b0),
		.retirq_i(rirq), .ret_addr_i(pc), .core_ack_i(cack), .irq_take_o(take),
		.irq_vector_o(vec), .stack_push_o(push), .stack_data_o(sdata), .in_high_o(inh),
		.in_low_o(inl));
	tlpiu_core_model u_core (.clk_i(clk_i), .rst_i(rst_i), .take_i(take), .vec_i(vec),
		.ret_cmd_i(retc), .lag_i(lag), .ack_o(cack), .retirq_o(rirq), .pc_o(pc));
	task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One classic Wishbone cycle; q keeps the read byte
	task automatic bus(input logic w, input logic [1:0] i, input logic [7:0] d, input logic [3:0] s);
		int n = 0;
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we  <= w;
		sel <= s;
		adr <= {i, 2'b00};
		dat <= {24'h000000, d};
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && n < 50);
		q = rdat[7:0];
		cyc <= 1'b0;
		stb <= 1'b0;
		if (n >= 50) num_errors++;
	endtask
	task automatic rd(input logic [1:0] i, input logic [7:0] e, input string nm);
		bus(1'b0, i, 8'h00, 4'hF);
		chk(nm, 32'(q), 32'(e));
	endtask
	task automatic wr(input logic [1:0] i, input logic [7:0] d);
		bus(1'b1, i, d, 4'h1);
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic fire();
		@(posedge clk_i) tov <= 1'b1;
		@(posedge clk_i) tov <= 1'b0;
	endtask
	task automatic ret();
		@(posedge clk_i) retc <= 1'b1;
		@(posedge clk_i) retc <= 1'b0;
		tick(2);
	endtask
	// Waits for a vector, checks it, waits for the core to take it
	task automatic wtk(input logic [20:0] v);
		int n = 0;
		while (take !== 1'b1 && n < 20) begin
			@(posedge clk_i);
			n++;
		end
		chk("vector", 32'(vec), 32'(v));
		chk("push", 32'(push), 32'h1);
		chk("return", 32'(sdata), 32'(pc - 21'h000001));
		while (take === 1'b1 && n < 40) begin
			@(posedge clk_i);
			n++;
		end
	endtask
	task automatic quiet();
		tick(8);
		chk("service", 32'({inh, inl}), 32'h0);
	endtask
	task automatic t_regs();
		rd(2'h0, 8'h00, "control");
		rd(2'h1, 8'h00, "mode");
		wr(2'h0, 8'h38);
		rd(2'h0, 8'h38, "enables");
		bus(1'b1, 2'h0, 8'h00, 4'h0);
		rd(2'h0, 8'h38, "no sel");
		wr(2'h2, 8'hA5);
		rd(2'h2, 8'hA5, "periph en");
		wr(2'h0, 8'h00);
	endtask
	task automatic t_flags();
		fire();
		@(posedge clk_i) extp <= 1'b1;
		upins <= 4'h5;
		tick(8);
		rd(2'h0, 8'h07, "polled");
		wr(2'h0, 8'h00);
		rd(2'h0, 8'h01, "mismatch");
		@(posedge clk_i) prd <= 1'b1;
		@(posedge clk_i) prd <= 1'b0;
		extp <= 1'b0;
		wr(2'h0, 8'h00);
		rd(2'h0, 8'h00, "cleared");
		quiet();
	endtask
	task automatic t_compat();
		@(posedge clk_i) lag <= 2'h3;
		wr(2'h0, 8'hA0);
		fire();
		wtk(21'h000008);
		rd(2'h0, 8'h24, "enable off");
		wr(2'h0, 8'h20);
		ret();
		rd(2'h0, 8'hA0, "enable on");
		wr(2'h2, 8'h01);
		wr(2'h0, 8'h80);
		@(posedge clk_i) preq <= 8'h01;
		quiet();
		wr(2'h0, 8'hC0);
		wtk(21'h000008);
		@(posedge clk_i) preq <= 8'h00;
		ret();
		rd(2'h0, 8'hC0, "gate on");
	endtask
	task automatic t_prio();
		@(posedge clk_i) lag <= 2'h0;
		epr <= 1'b1;
		wr(2'h1, 8'h80);
		rd(2'h1, 8'h80, "mode");
		wr(2'h0, 8'h00);
		fire();
		@(posedge clk_i) extp <= 1'b1;
		tick(8);
		wr(2'h0, 8'h66);
		quiet();
		wr(2'h0, 8'hF6);
		wtk(21'h000008);
		rd(2'h0, 8'h76, "high off");
		wr(2'h0, 8'h74);
		ret();
		wtk(21'h000018);
		rd(2'h0, 8'hB4, "low off");
		@(posedge clk_i) extp <= 1'b0;
		tick(8);
		@(posedge clk_i) extp <= 1'b1;
		wtk(21'h000008);
		chk("nested", 32'({inh, inl}), 32'h3);
	endtask
	task automatic end_of_test();
		if (num_errors == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// Cuts a hang short
	always @(posedge clk_i) begin
		cyc_n++;
		if (cyc_n == 20000) begin
			num_errors++;
			end_of_test();
		end
	end
	initial begin
		tick(10);
		rst_i <= 1'b0;
		t_regs();
		t_flags();
		t_compat();
		t_prio();
		end_of_test();
	end
endmodule // tb
bind tlpiu_top tlpiu_asserts u_chk (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
	.wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .core_ack_i(core_ack_i),
	.retirq_i(retirq_i), .irq_take_o(irq_take_o), .irq_vector_o(irq_vector_o),
	.stack_push_o(stack_push_o), .stack_data_o(stack_data_o), .in_high_o(in_high_o),
	.in_low_o(in_low_o));
